// >>> rtl/pif_irq_flags.sv
// peripheral interrupt flag and enable registers with axi4-lite slave
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`default_nettype none
// Functional notes
// [R1] oscillator failure sets flag bit 7
// [R2] comparator change sets flag bit 6
// [R3] memory write completion sets flag bit 4
// [R4] bus collision sets flag bit 3
// [R5] low voltage sets flag bit 2
// [R6] third timer overflow sets flag bit 1
// [R7] capture/compare sets bit 0, not pwm
// [R8] flag register bit 5 reads zero
// [R9] invalid can message sets bit 7
// [R10] can bus activity sets wake bit 6
// [R11] any can error sets bit 5
// [R12] bit 4: buffer two or any tx
// [R13] tx buffers one, zero set bits 3,2
// [R14] bit 1: buffer one or any rx
// [R15] bit 0: rx zero, zero, watermark (code reads bit 0 as zero in mode 2 too)
// [R16] modes 1,2 force footnoted bits zero
// [R17] software sets peripheral enable first
// [R18] enable bits 0..6 gate their sources
// [R19] software keeps parallel port enable clear
// [R20] comparator, capcomp flags only large package
// [R21] flags set regardless of enables
// [R22] with priorities, peripheral enable gates low
// [R23] request needs flag, enable and globals
module pif_irq_flags
    import pif_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // peripheral events, same clock
    input wire pif_sys_evt_t sys_evt_i,
    input wire pif_can_evt_t can_evt_i,
    input wire logic [7:0] periph_one_flags_i,
    input wire logic [7:0] low_priority_i,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt request
    output logic periph_irq_o
);
    logic [7:0] flags_two_r, flags_two_nxt;
    logic [7:0] can_flags_r, can_flags_nxt;
    logic [7:0] enables_r, enables_nxt;
    logic [7:0] control_r, control_nxt;
    logic irq_r, irq_nxt;
    logic aw_held_r, aw_held_nxt;
    logic w_held_r, w_held_nxt;
    logic [3:0] awaddr_r, awaddr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    pif_wr_state_t wr_state_r, wr_state_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;

    logic [1:0] can_mode;
    logic large_pkg;
    logic [7:0] sys_set, can_set, can_view, flags_two_view;
    logic do_write;
    logic [7:0] clr_two, clr_can;

    assign can_mode = control_r[PIF_B_CAN_MODE_LO +: 2];
    assign large_pkg = control_r[PIF_B_LARGE_PKG];

    // event decode, independent of any enable
    always_comb
    begin
        sys_set = 8'h00;
        sys_set[PIF_B_OSC_FAIL] = sys_evt_i.osc_fail; // R1 R21
        sys_set[PIF_B_COMPARATOR] = sys_evt_i.comparator_change & large_pkg; // R2 R20
        sys_set[PIF_B_NVM_DONE] = sys_evt_i.nvm_write_done; // R3
        sys_set[PIF_B_BUS_COLL] = sys_evt_i.bus_collision; // R4
        sys_set[PIF_B_VOLTAGE] = sys_evt_i.voltage_detect; // R5
        sys_set[PIF_B_TIMER_THREE] = sys_evt_i.timer_three_overflow; // R6
        // pwm mode leaves the capture flag unused
        sys_set[PIF_B_CAPCOMP] = sys_evt_i.enhanced_capcomp & ~sys_evt_i.capcomp_pwm_mode
            & large_pkg; // R7 R20
        can_set = 8'h00;
        can_set[PIF_B_INVALID] = can_evt_i.invalid_msg; // R9
        can_set[PIF_B_WAKE] = can_evt_i.wake; // R10
        can_set[PIF_B_CAN_ERR] = can_evt_i.error; // R11
        if (can_mode == PIF_CAN_MODE0)
        begin
            can_set[PIF_B_TX_TWO] = can_evt_i.tx_two_done; // R12
            can_set[PIF_B_TX_ONE] = can_evt_i.tx_one_done; // R13
            can_set[PIF_B_TX_ZERO] = can_evt_i.tx_zero_done; // R13
            can_set[PIF_B_RX_ONE] = can_evt_i.rx_one_new; // R14
            can_set[PIF_B_RX_ZERO] = can_evt_i.rx_zero_new; // R15
        end
        else
        begin
            can_set[PIF_B_TX_TWO] = can_evt_i.tx_two_done | can_evt_i.tx_one_done
                | can_evt_i.tx_zero_done; // R12
            can_set[PIF_B_RX_ONE] = can_evt_i.rx_one_new | can_evt_i.rx_zero_new; // R14
        end
    end

    // visible values: footnoted bits forced to zero outside mode 0
    always_comb
    begin
        can_view = can_flags_r;
        if (can_mode != PIF_CAN_MODE0)
        begin
            can_view[PIF_B_TX_ONE] = 1'b0; // R16
            can_view[PIF_B_TX_ZERO] = 1'b0; // R16
            can_view[PIF_B_RX_ZERO] = 1'b0; // R15 R16
        end
        flags_two_view = flags_two_r;
        flags_two_view[PIF_B_UNIMPL] = 1'b0; // R8
        if (!large_pkg)
        begin
            flags_two_view[PIF_B_COMPARATOR] = 1'b0; // R20
            flags_two_view[PIF_B_CAPCOMP] = 1'b0; // R20
        end
    end

    // write strobe: both channels held, response slot free
    assign do_write = aw_held_r & w_held_r & (wr_state_r == PIF_WR_IDLE);

    // software writes zero to clear; set wins over clear
    always_comb
    begin
        clr_two = 8'h00;
        clr_can = 8'h00;
        if (do_write && wstrb_r && awaddr_r == PIF_ADDR_FLAGS_TWO)
        begin
            clr_two = ~wdata_r;
        end
        if (do_write && wstrb_r && awaddr_r == PIF_ADDR_CAN_FLAGS)
        begin
            clr_can = ~wdata_r;
        end
        flags_two_nxt = ((flags_two_r & ~clr_two) | sys_set) & ~(8'h01 << PIF_B_UNIMPL);
        can_flags_nxt = (can_flags_r & ~clr_can) | can_set;
        // watermark only exists in mode 2, raw mode 1 keeps bit 0 clear
        if (can_mode == PIF_CAN_MODE2)
        begin
            can_flags_nxt[PIF_B_RX_ZERO] = (can_flags_r[PIF_B_RX_ZERO]
                & ~clr_can[PIF_B_RX_ZERO]) | can_evt_i.fifo_watermark; // R15
        end
        else if (can_mode == PIF_CAN_MODE1)
        begin
            can_flags_nxt[PIF_B_RX_ZERO] = 1'b0; // R15
        end
        enables_nxt = enables_r;
        control_nxt = control_r;
        if (do_write && wstrb_r && awaddr_r == PIF_ADDR_ENABLES_ONE)
        begin
            enables_nxt = wdata_r; // R18
        end
        if (do_write && wstrb_r && awaddr_r == PIF_ADDR_CONTROL)
        begin
            control_nxt = wdata_r & PIF_CONTROL_MASK;
        end
    end

    // request: flag and enable and globals; priority mode gates low ones only
    always_comb
    begin
        logic [7:0] pend_one;
        logic any_low;
        logic any_high;
        pend_one = periph_one_flags_i & enables_r; // R18 R23
        any_low = |(pend_one & ~low_priority_i);
        any_high = |(pend_one & low_priority_i);
        if (control_r[PIF_B_PRIO_EN])
        begin
            // high-priority sources bypass the peripheral enable
            irq_nxt = any_high | (any_low & control_r[PIF_B_PERIPH_EN]); // R22 R23
        end
        else
        begin
            irq_nxt = (any_low | any_high) & control_r[PIF_B_PERIPH_EN]; // R17 R23
        end
    end

    // axi4-lite write path
    always_comb
    begin
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        wr_state_nxt = wr_state_r;
        if (s_axi_awvalid && !aw_held_r)
        begin
            aw_held_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_r)
        begin
            w_held_nxt = 1'b1;
            wdata_nxt = s_axi_wdata[7:0];
            wstrb_nxt = s_axi_wstrb[0];
        end
        case (wr_state_r)
            PIF_WR_IDLE:
            begin
                if (do_write)
                begin
                    aw_held_nxt = 1'b0;
                    w_held_nxt = 1'b0;
                    bvalid_nxt = 1'b1;
                    bresp_nxt = (awaddr_r[1:0] == 2'h0) ? PIF_RESP_OKAY : PIF_RESP_SLVERR;
                    wr_state_nxt = PIF_WR_RESP;
                end
            end
            PIF_WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    bvalid_nxt = 1'b0;
                    wr_state_nxt = PIF_WR_IDLE;
                end
            end
            default:
            begin
                wr_state_nxt = PIF_WR_IDLE;
            end
        endcase
        awready_nxt = ~aw_held_nxt;
        wready_nxt = ~w_held_nxt;
    end

    // axi4-lite read path
    always_comb
    begin
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (rvalid_r && s_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = PIF_RESP_OKAY;
            case (s_axi_araddr)
                PIF_ADDR_FLAGS_TWO: rdata_nxt = flags_two_view; // R8
                PIF_ADDR_CAN_FLAGS: rdata_nxt = can_view; // R16
                PIF_ADDR_ENABLES_ONE: rdata_nxt = enables_r;
                PIF_ADDR_CONTROL: rdata_nxt = control_r;
                default:
                begin
                    rdata_nxt = 8'h00;
                    rresp_nxt = PIF_RESP_SLVERR;
                end
            endcase
        end
        arready_nxt = ~rvalid_nxt;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            flags_two_r <= PIF_RST_FLAGS;
            can_flags_r <= PIF_RST_FLAGS;
            enables_r <= PIF_RST_ENABLES;
            control_r <= PIF_RST_CONTROL;
            irq_r <= 1'b0;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r <= 8'h00;
            wstrb_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= PIF_RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= PIF_RESP_OKAY;
            rdata_r <= 8'h00;
            wr_state_r <= PIF_WR_IDLE;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            arready_r <= 1'b1;
        end
        else
        begin
            flags_two_r <= flags_two_nxt;
            can_flags_r <= can_flags_nxt;
            enables_r <= enables_nxt;
            control_r <= control_nxt;
            irq_r <= irq_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            wr_state_r <= wr_state_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            arready_r <= arready_nxt;
        end
    end

    // ready flops mirror the free slots, so no output has logic after a flop
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = {24'h000000, rdata_r};
    assign periph_irq_o = irq_r;

    property p_osc_set;
        @(posedge core_clk_i) disable iff (srst_i)
        sys_evt_i.osc_fail |=> flags_two_r[PIF_B_OSC_FAIL];
    endproperty
    a_osc_set: assert property (p_osc_set) else $error("osc flag not set"); // R1

    property p_nvm_hold;
        @(posedge core_clk_i) disable iff (srst_i)
        flags_two_r[PIF_B_NVM_DONE] && !(do_write && awaddr_r == PIF_ADDR_FLAGS_TWO)
            |=> flags_two_r[PIF_B_NVM_DONE];
    endproperty
    a_nvm_hold: assert property (p_nvm_hold) else $error("nvm flag lost"); // R3

    property p_timer_set;
        @(posedge core_clk_i) disable iff (srst_i)
        sys_evt_i.timer_three_overflow |=> flags_two_r[PIF_B_TIMER_THREE];
    endproperty
    a_timer_set: assert property (p_timer_set) else $error("timer flag not set"); // R6

    property p_unimpl_zero;
        @(posedge core_clk_i) disable iff (srst_i)
        s_axi_arvalid && !rvalid_r && s_axi_araddr == PIF_ADDR_FLAGS_TWO
            |=> !s_axi_rdata[PIF_B_UNIMPL];
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("bit five read one"); // R8

    property p_wake_set;
        @(posedge core_clk_i) disable iff (srst_i)
        can_evt_i.wake |=> can_flags_r[PIF_B_WAKE];
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake flag not set"); // R10

    property p_forced_zero;
        @(posedge core_clk_i) disable iff (srst_i)
        s_axi_arvalid && !rvalid_r && s_axi_araddr == PIF_ADDR_CAN_FLAGS
            && can_mode != PIF_CAN_MODE0 |=> (s_axi_rdata[7:0] & 8'h0D) == 8'h00;
    endproperty
    a_forced_zero: assert property (p_forced_zero) else $error("footnoted bit set"); // R16

    property p_small_pkg;
        @(posedge core_clk_i) disable iff (srst_i)
        !large_pkg && sys_evt_i.comparator_change && !flags_two_r[PIF_B_COMPARATOR]
            |=> !flags_two_r[PIF_B_COMPARATOR];
    endproperty
    a_small_pkg: assert property (p_small_pkg) else $error("reserved flag set"); // R20

    property p_irq_cause;
        @(posedge core_clk_i) disable iff (srst_i)
        periph_irq_o |-> $past(control_r[PIF_B_PRIO_EN] || control_r[PIF_B_PERIPH_EN])
            && $past(|(periph_one_flags_i & enables_r));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause"); // R23

    property p_irq_no_peripheral_irq_enable;
        @(posedge core_clk_i) disable iff (srst_i)
        !control_r[PIF_B_PRIO_EN] && !control_r[PIF_B_PERIPH_EN] |=> !periph_irq_o;
    endproperty
    a_irq_no_peripheral_irq_enable: assert property (p_irq_no_peripheral_irq_enable) else $error("irq while disabled"); // R23
endmodule
`default_nettype wire

// >>> rtl/pif_pkg.sv
// package for the peripheral interrupt flag and enable block
package pif_pkg;
    // register byte addresses (chosen)
    localparam logic [3:0] PIF_ADDR_FLAGS_TWO = 4'h0;
    localparam logic [3:0] PIF_ADDR_CAN_FLAGS = 4'h4;
    localparam logic [3:0] PIF_ADDR_ENABLES_ONE = 4'h8;
    localparam logic [3:0] PIF_ADDR_CONTROL = 4'hC;
    // reset values
    localparam logic [7:0] PIF_RST_FLAGS = 8'h00;
    localparam logic [7:0] PIF_RST_ENABLES = 8'h00;
    localparam logic [7:0] PIF_RST_CONTROL = 8'h00;
    // peripheral_flags_two fields
    localparam int PIF_B_OSC_FAIL = 7;
    localparam int PIF_B_COMPARATOR = 6;
    localparam int PIF_B_UNIMPL = 5;
    localparam int PIF_B_NVM_DONE = 4;
    localparam int PIF_B_BUS_COLL = 3;
    localparam int PIF_B_VOLTAGE = 2;
    localparam int PIF_B_TIMER_THREE = 1;
    localparam int PIF_B_CAPCOMP = 0;
    // can_event_flags fields
    localparam int PIF_B_INVALID = 7;
    localparam int PIF_B_WAKE = 6;
    localparam int PIF_B_CAN_ERR = 5;
    localparam int PIF_B_TX_TWO = 4;
    localparam int PIF_B_TX_ONE = 3;
    localparam int PIF_B_TX_ZERO = 2;
    localparam int PIF_B_RX_ONE = 1;
    localparam int PIF_B_RX_ZERO = 0;
    // control register fields
    localparam int PIF_B_PERIPH_EN = 0;
    localparam int PIF_B_PRIO_EN = 1;
    localparam int PIF_B_CAN_MODE_LO = 2;
    localparam int PIF_B_LARGE_PKG = 4;
    localparam logic [7:0] PIF_CONTROL_MASK = 8'h1F;
    // axi responses
    localparam logic [1:0] PIF_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIF_RESP_SLVERR = 2'h2;
    // can operating modes
    localparam logic [1:0] PIF_CAN_MODE0 = 2'h0;
    localparam logic [1:0] PIF_CAN_MODE1 = 2'h1;
    localparam logic [1:0] PIF_CAN_MODE2 = 2'h2;

    // event pulses and the pwm mode level from the peripherals
    typedef struct packed {
        logic osc_fail;
        logic comparator_change;
        logic nvm_write_done;
        logic bus_collision;
        logic voltage_detect;
        logic timer_three_overflow;
        logic enhanced_capcomp;
        logic capcomp_pwm_mode;
    } pif_sys_evt_t;

    typedef struct packed {
        logic invalid_msg;
        logic wake;
        logic error;
        logic tx_two_done;
        logic tx_one_done;
        logic tx_zero_done;
        logic rx_one_new;
        logic rx_zero_new;
        logic fifo_watermark;
    } pif_can_evt_t;

    typedef enum logic [1:0] {
        PIF_WR_IDLE,
        PIF_WR_RESP
    } pif_wr_state_t;
endpackage

// >>> tb/pif_evt_model.sv
// peripheral event source model feeding the flag block
`default_nettype none
module pif_evt_model
    import pif_pkg::*;
(
    // clock
    input wire logic core_clk_i,
    // events and levels toward the flag block
    output var pif_sys_evt_t sys_evt_o,
    output var pif_can_evt_t can_evt_o,
    output var logic [7:0] periph_one_flags_o,
    output var logic [7:0] low_priority_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // pwm mode is a level, so it must survive every pulse
    logic pwm_mode_r;

    initial
    begin
        sys_evt_o = '0;
        can_evt_o = '0;
        periph_one_flags_o = 8'h00;
        low_priority_o = 8'h00;
        pwm_mode_r = 1'b0;
    end

    // levels change right after a rising edge
    task automatic set_levels(input logic pwm, input logic [7:0] flags, input logic [7:0] prio);
        begin
            pwm_mode_r = pwm;
            sys_evt_o <= pif_sys_evt_t'({7'h00, pwm});
            periph_one_flags_o <= flags;
            low_priority_o <= prio;
        end
    endtask

    // one-cycle pulses, sampled at the next rising edge
    task automatic fire(input logic [7:0] s, input logic [8:0] c);
        begin
            sys_evt_o <= pif_sys_evt_t'({s[7:1], pwm_mode_r});
            can_evt_o <= pif_can_evt_t'(c);
            @(posedge core_clk_i);
            sys_evt_o <= pif_sys_evt_t'({7'h00, pwm_mode_r});
            can_evt_o <= '0;
        end
    endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// register-level testbench for the peripheral flag and enable block
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb
    import pif_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i, srst_i;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, periph_irq_o;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    pif_sys_evt_t sys_evt;
    pif_can_evt_t can_evt;
    logic [7:0] p1_flags, low_prio;
    int n_mismatch, num_checks;

    pif_evt_model i_src (.core_clk_i(core_clk_i), .sys_evt_o(sys_evt), .can_evt_o(can_evt),
        .periph_one_flags_o(p1_flags), .low_priority_o(low_prio));

    pif_irq_flags i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .sys_evt_i(sys_evt),
        .can_evt_i(can_evt), .periph_one_flags_i(p1_flags), .low_priority_i(low_prio),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .periph_irq_o(periph_irq_o));

    initial
    begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    task automatic final_report;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_mismatch);
            if (n_mismatch == 0 && num_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    // handshakes judged at the falling edge, so the rising edge never races the flops
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ah, wh, bh;
        logic [1:0] r;
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h000000, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            bh = 1'b0;
            while (!bh)
            begin
                @(negedge core_clk_i);
                ah = s_axi_awvalid && s_axi_awready;
                wh = s_axi_wvalid && s_axi_wready;
                bh = s_axi_bvalid;
                r = s_axi_bresp;
                @(posedge core_clk_i);
                if (ah) s_axi_awvalid <= 1'b0;
                if (wh) s_axi_wvalid <= 1'b0;
            end
            `CHK(r, er)
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] ed);
        logic ah, rh;
        logic [31:0] d;
        logic [1:0] r;
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            rh = 1'b0;
            while (!rh)
            begin
                @(negedge core_clk_i);
                ah = s_axi_arvalid && s_axi_arready;
                rh = s_axi_rvalid;
                d = s_axi_rdata;
                r = s_axi_rresp;
                @(posedge core_clk_i);
                if (ah) s_axi_arvalid <= 1'b0;
            end
            `CHK({r, d}, {PIF_RESP_OKAY, 24'h000000, ed})
        end
    endtask

    task automatic ctl(input logic [7:0] v);
        wr(PIF_ADDR_CONTROL, v, PIF_RESP_OKAY);
    endtask

    // request is registered, a few edges of slack
    task automatic chk_irq(input logic e);
        begin
            repeat (3) @(posedge core_clk_i);
            @(negedge core_clk_i);
            `CHK(periph_irq_o, e)
            @(posedge core_clk_i);
        end
    endtask

    // about 45 transfers of under 10 cycles each; wide margin
    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        n_mismatch++;
        final_report();
    end

    initial
    begin
        n_mismatch = 0;
        num_checks = 0;
        srst_i = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_arvalid, s_axi_wdata} = '0;
        // responses always accepted, so ready never toggles between calls
        {s_axi_bready, s_axi_rready} = 2'h3;
        s_axi_wstrb = 4'hF;
        repeat (8) @(posedge core_clk_i);
        srst_i <= 1'b0;
        rd(PIF_ADDR_FLAGS_TWO, PIF_RST_FLAGS);
        rd(PIF_ADDR_CAN_FLAGS, PIF_RST_FLAGS);
        rd(PIF_ADDR_ENABLES_ONE, PIF_RST_ENABLES);
        rd(PIF_ADDR_CONTROL, PIF_RST_CONTROL);
        // large package, all enables off: flags still latch
        ctl(8'h10);
        i_src.fire(8'hFE, 9'h000);
        rd(PIF_ADDR_FLAGS_TWO, 8'hDF);
        wr(PIF_ADDR_FLAGS_TWO, 8'hFF, PIF_RESP_OKAY);
        rd(PIF_ADDR_FLAGS_TWO, 8'hDF);
        wr(PIF_ADDR_FLAGS_TWO, 8'h00, PIF_RESP_OKAY);
        rd(PIF_ADDR_FLAGS_TWO, 8'h00);
        // capture event ignored in pwm mode
        i_src.set_levels(1'b1, 8'h00, 8'h00);
        // level and pulse share the event bus, one edge apart
        @(posedge core_clk_i);
        i_src.fire(8'h02, 9'h000);
        rd(PIF_ADDR_FLAGS_TWO, 8'h00);
        i_src.set_levels(1'b0, 8'h00, 8'h00);
        // small package hides comparator and capture flags
        ctl(8'h00);
        i_src.fire(8'h62, 9'h000);
        rd(PIF_ADDR_FLAGS_TWO, 8'h10);
        wr(PIF_ADDR_FLAGS_TWO, 8'h00, PIF_RESP_OKAY);
        // can mode 0, every source
        i_src.fire(8'h00, 9'h1FE);
        rd(PIF_ADDR_CAN_FLAGS, 8'hFF);
        wr(PIF_ADDR_CAN_FLAGS, 8'h00, PIF_RESP_OKAY);
        rd(PIF_ADDR_CAN_FLAGS, 8'h00);
        // mode 1: tx one and rx zero fold into the any flags
        ctl(8'h14);
        i_src.fire(8'h00, 9'h013);
        rd(PIF_ADDR_CAN_FLAGS, 8'h12);
        wr(PIF_ADDR_CAN_FLAGS, 8'h00, PIF_RESP_OKAY);
        // mode 2: watermark kept off the read
        ctl(8'h18);
        i_src.fire(8'h00, 9'h00D);
        rd(PIF_ADDR_CAN_FLAGS, 8'h12);
        wr(PIF_ADDR_CAN_FLAGS, 8'h00, PIF_RESP_OKAY);
        // strobe-low and misaligned writes both leave the enables untouched
        s_axi_wstrb <= 4'hE;
        wr(PIF_ADDR_ENABLES_ONE, 8'h7F, PIF_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        wr(4'h9, 8'h7F, PIF_RESP_SLVERR);
        rd(PIF_ADDR_ENABLES_ONE, 8'h00);
        ctl(8'h11);
        for (int i = 0; i < 7; i++)
        begin
            i_src.set_levels(1'b0, 8'(1 << i), 8'h00);
            wr(PIF_ADDR_ENABLES_ONE, 8'(1 << ((i + 1) % 7)), PIF_RESP_OKAY);
            chk_irq(1'b0);
            wr(PIF_ADDR_ENABLES_ONE, 8'(1 << i), PIF_RESP_OKAY);
            chk_irq(1'b1);
        end
        rd(PIF_ADDR_ENABLES_ONE, 8'h40);
        ctl(8'h10);
        chk_irq(1'b0);
        // priorities on: high-priority source bypasses the peripheral enable
        ctl(8'h12);
        i_src.set_levels(1'b0, 8'h40, 8'h40);
        chk_irq(1'b1);
        i_src.set_levels(1'b0, 8'h40, 8'h00);
        chk_irq(1'b0);
        ctl(8'h13);
        chk_irq(1'b1);
        final_report();
    end
endmodule
`default_nettype wire
